// ---- logic/pss_device.sv ----
// Module end: power-on detect, orderly and emergency off, sleep policy.
// Assumes link inputs synchronous to clk and a host that keeps its timing.
`timescale 1ns/100ps
`default_nettype none
module pss_device
	import pss_pkg::*;
#(
	parameter int unsigned PWR_ON_MIN = PWR_ON_MIN_CYC,
	parameter int unsigned IO_UP_DELAY = IO_UP_DELAY_CYC,
	parameter int unsigned EMERG_MIN = EMERG_PULSE_CYC,
	parameter int unsigned IDLE_TIMEOUT = IDLE_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	pss_link_if.device link,
	input wire logic tasksBusy,
	output logic poweredOn,
	output logic asleep,
	output logic wiped,
	output logic [1:0] sleepConfig
);
	pss_state_e state_q;
	logic [CNT_W-1:0] onCnt_q;
	logic [CNT_W-1:0] rampCnt_q;
	logic [CNT_W-1:0] emCnt_q;
	logic [CNT_W-1:0] idleCnt_q;
	logic ioGood_q;
	logic emergencyHit;
	logic wantSleep;
	logic idleDone;
	logic pinLow;
	logic offAccepted;
	logic rampDone;

	// Saturating compare helper shared by the four timers
	function automatic logic reached(input logic [CNT_W-1:0] cnt, input int unsigned lim);
		reached = cnt >= CNT_W'(lim);
	endfunction

	// States in which the module is fully up
	function automatic logic supplyState(input pss_state_e s);
		supplyState = s == PSS_ACTIVE || s == PSS_SLEEP;
	endfunction

	// Power-up phases in which the supply ramp timer runs
	function automatic logic pressPhase(input pss_state_e s);
		pressPhase = s == PSS_TRIGGER || s == PSS_RAMP;
	endfunction

	// Pin decode; the request pin is active low and pulled up when released
	assign pinLow = !link.powerOnRequestN;
	// Power-off only counts with the request pin inactive
	assign offAccepted = link.powerOffCommand && !pinLow;

	// Emergency pulse counts only while the request pin stays high
	always_ff @(posedge clk) begin
		if (srst || link.emergencyOffN || !link.powerOnRequestN) begin
			emCnt_q <= '0;
		end else if (!reached(emCnt_q, EMERG_MIN)) begin
			emCnt_q <= emCnt_q + 1'b1;
		end
	end
	assign emergencyHit = reached(emCnt_q, EMERG_MIN) && state_q != PSS_OFF;

	// Power-on request low time; shorter pulses are not a trigger
	// Keeps counting through the trigger phase so the press is timed from its fall
	always_ff @(posedge clk) begin
		if (srst || !pinLow || (state_q != PSS_OFF && state_q != PSS_TRIGGER)) begin
			onCnt_q <= '0;
		end else if (!reached(onCnt_q, PWR_ON_MIN)) begin
			onCnt_q <= onCnt_q + 1'b1;
		end
	end

	// Supply ramp timer, started at the press: waiting for the full trigger
	// first would overrun the supply deadline; needs IO_UP_DELAY below PWR_ON_MIN
	always_ff @(posedge clk) begin
		if (srst || !pressPhase(state_q)) begin
			rampCnt_q <= '0;
		end else if (!reached(rampCnt_q, IO_UP_DELAY)) begin
			rampCnt_q <= rampCnt_q + 1'b1;
		end
	end
	assign rampDone = pressPhase(state_q) && reached(rampCnt_q, IO_UP_DELAY);

	// Sleep request per configuration
	always_comb begin
		case (sleepConfig)
			SLEEP_CFG_DTR: wantSleep = link.dtrN;
			SLEEP_CFG_AUTO: wantSleep = !tasksBusy;
			default: wantSleep = 1'b0;
		endcase
	end

	// Idle timeout, restarted whenever the sleep reason goes away
	always_ff @(posedge clk) begin
		if (srst || !wantSleep || state_q != PSS_ACTIVE) begin
			idleCnt_q <= '0;
		end else if (!reached(idleCnt_q, IDLE_TIMEOUT)) begin
			idleCnt_q <= idleCnt_q + 1'b1;
		end
	end
	assign idleDone = (sleepConfig == SLEEP_CFG_DTR) ? reached(idleCnt_q, IDLE_TIMEOUT)
		: wantSleep;

	// Main power sequence
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= PSS_OFF;
		end else if (emergencyHit) begin
			state_q <= PSS_OFF;
		end else begin
			case (state_q)
				PSS_OFF: begin
					if (pinLow) begin
						state_q <= PSS_TRIGGER;
					end
				end
				// A press released before the minimum time is dropped
				PSS_TRIGGER: begin
					if (reached(onCnt_q, PWR_ON_MIN)) begin
						state_q <= PSS_RAMP;
					end else if (!pinLow) begin
						state_q <= PSS_OFF;
					end
				end
				PSS_RAMP: begin
					if (reached(rampCnt_q, IO_UP_DELAY)) begin
						state_q <= PSS_ACTIVE;
					end
				end
				PSS_ACTIVE: begin
					if (offAccepted) begin
						state_q <= PSS_OFF;
					end else if (idleDone) begin
						state_q <= PSS_SLEEP;
					end
				end
				PSS_SLEEP: begin
					if (offAccepted) begin
						state_q <= PSS_OFF;
					end else if (!wantSleep) begin
						state_q <= PSS_ACTIVE;
					end
				end
				default: state_q <= PSS_OFF;
			endcase
		end
	end

	// Sleep configuration; emergency off returns it to reset value
	always_ff @(posedge clk) begin
		if (srst || emergencyHit) begin
			sleepConfig <= SLEEP_CFG_RESET;
		end else if (link.sleepConfigCommand && link.sleepConfigValue <= SLEEP_CFG_NEVER
			&& state_q != PSS_OFF && state_q != PSS_TRIGGER) begin
			sleepConfig <= link.sleepConfigValue;
		end
	end

	// Supply indication; it may show briefly during a press that is then dropped
	always_ff @(posedge clk) begin
		if (srst) begin
			ioGood_q <= 1'b0;
		end else begin
			ioGood_q <= !emergencyHit && (supplyState(state_q) || rampDone);
		end
	end
	assign link.ioSupplyGood = ioGood_q;

	// Powered once the trigger is accepted, not during the press itself
	always_ff @(posedge clk) begin
		if (srst) begin
			poweredOn <= 1'b0;
		end else begin
			poweredOn <= !emergencyHit && (supplyState(state_q) || state_q == PSS_RAMP);
		end
	end

	// Sleep indication, dropped at once by an emergency off
	always_ff @(posedge clk) begin
		if (srst) begin
			asleep <= 1'b0;
		end else begin
			asleep <= !emergencyHit && state_q == PSS_SLEEP;
		end
	end

	// Wipe flag; set wins over clear, and only an accepted power-on clears it
	always_ff @(posedge clk) begin
		if (srst) begin
			wiped <= 1'b0;
		end else if (emergencyHit) begin
			wiped <= 1'b1;
		end else if (state_q == PSS_RAMP) begin
			wiped <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- inc/pss_pkg.sv ----
// Package for the power and sleep sequencer: timing counts and enumerations.
// Assumes a 125 MHz system clock shared by the module end and the host end.
package pss_pkg;
	localparam int unsigned CLK_MHZ = 125;
	// Times in microseconds, as printed
	localparam int unsigned PWR_ON_MIN_US = 25000;
	localparam int unsigned IO_UP_MAX_US = 25000;
	localparam int unsigned EMERG_PULSE_US = 10000;
	// Least times round up, longest times round down
	localparam int unsigned PWR_ON_MIN_CYC = (PWR_ON_MIN_US * CLK_MHZ + 0) / 1;
	localparam int unsigned IO_UP_MAX_CYC = (IO_UP_MAX_US * CLK_MHZ) / 1;
	localparam int unsigned EMERG_PULSE_CYC = EMERG_PULSE_US * CLK_MHZ;
	// Default supply ramp delay and sleep idle timeout, in cycles
	localparam int unsigned IO_UP_DELAY_CYC = 1000;
	localparam int unsigned IDLE_TIMEOUT_CYC = 1000;
	localparam int unsigned CNT_W = 24;
	// Sleep configuration codes
	localparam logic [1:0] SLEEP_CFG_DTR = 2'h0;
	localparam logic [1:0] SLEEP_CFG_AUTO = 2'h1;
	localparam logic [1:0] SLEEP_CFG_NEVER = 2'h2;
	localparam logic [1:0] SLEEP_CFG_RESET = 2'h2;
	typedef enum logic [2:0] {
		PSS_OFF,
		PSS_TRIGGER,
		PSS_RAMP,
		PSS_ACTIVE,
		PSS_SLEEP
	} pss_state_e;
endpackage

// ---- inc/pss_link_if.sv ----
// Pin and command link between the host processor and the cellular module.
// Resolves the pulled-up power-on request from the host's open-drain enable.
`timescale 1ns/100ps
`default_nettype none
interface pss_link_if;
	logic powerOnRequestNOut;
	logic powerOnRequestNOe;
	logic powerOnRequestN;
	logic emergencyOffN;
	logic dtrN;
	logic powerOffCommand;
	logic sleepConfigCommand;
	logic [1:0] sleepConfigValue;
	logic ioSupplyGood;
	// Internal pull-up holds the pin high while undriven
	assign powerOnRequestN = powerOnRequestNOe ? powerOnRequestNOut : 1'b1;
	modport device (
		input powerOnRequestN,
		input emergencyOffN,
		input dtrN,
		input powerOffCommand,
		input sleepConfigCommand,
		input sleepConfigValue,
		output ioSupplyGood
	);
	modport host (
		output powerOnRequestNOut,
		output powerOnRequestNOe,
		input powerOnRequestN,
		output emergencyOffN,
		output dtrN,
		output powerOffCommand,
		output sleepConfigCommand,
		output sleepConfigValue,
		input ioSupplyGood
	);
endinterface
`default_nettype wire

// ---- logic/pss_host.sv ----
// Host end: drives power-on, power-off, emergency off and sleep settings.
// Assumes one-cycle user requests, synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pss_host
	import pss_pkg::*;
#(
	parameter int unsigned PWR_ON_MIN = PWR_ON_MIN_CYC,
	parameter int unsigned EMERG_LEN = EMERG_PULSE_CYC
) (
	input wire logic clk,
	input wire logic srst,
	pss_link_if.host link,
	input wire logic startReq,
	input wire logic stopReq,
	input wire logic emergencyReq,
	input wire logic cfgReq,
	input wire logic [1:0] cfgValue,
	input wire logic dtrNIn,
	output logic busy,
	output logic moduleUp
);
	typedef enum logic [1:0] {HS_IDLE, HS_PRESS, HS_EMERG} pss_hstate_e;
	pss_hstate_e hs_q;
	logic [CNT_W-1:0] cnt_q;
	logic pressOe_q;
	logic emN_q;
	logic offCmd_q;
	logic cfgCmd_q;
	logic [1:0] cfgVal_q;
	logic dtr_q;

	// Press sequencing: hold low 25ms then release to the pull-up
	always_ff @(posedge clk) begin
		if (srst) begin
			hs_q <= HS_IDLE;
			cnt_q <= '0;
			pressOe_q <= 1'b0;
			emN_q <= 1'b1;
		end else begin
			case (hs_q)
				HS_IDLE: begin
					cnt_q <= '0;
					if (emergencyReq) begin
						hs_q <= HS_EMERG;
						emN_q <= 1'b0;
					end else if (startReq) begin
						hs_q <= HS_PRESS;
						pressOe_q <= 1'b1;
					end
				end
				HS_PRESS: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q >= CNT_W'(PWR_ON_MIN)) begin
						hs_q <= HS_IDLE;
						pressOe_q <= 1'b0;
					end
				end
				HS_EMERG: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q >= CNT_W'(EMERG_LEN)) begin
						hs_q <= HS_IDLE;
						emN_q <= 1'b1;
					end
				end
				default: hs_q <= HS_IDLE;
			endcase
		end
	end

	// Power-off command only when the request pin is inactive; sleep config commands pass at any time
	always_ff @(posedge clk) begin
		if (srst) begin
			offCmd_q <= 1'b0;
			cfgCmd_q <= 1'b0;
			cfgVal_q <= SLEEP_CFG_RESET;
			dtr_q <= 1'b1;
			busy <= 1'b0;
			moduleUp <= 1'b0;
		end else begin
			offCmd_q <= stopReq && hs_q == HS_IDLE && !startReq;
			cfgCmd_q <= cfgReq;
			if (cfgReq) cfgVal_q <= cfgValue;
			dtr_q <= dtrNIn;
			busy <= hs_q != HS_IDLE;
			moduleUp <= link.ioSupplyGood;
		end
	end

	assign link.powerOnRequestNOut = 1'b0;
	assign link.powerOnRequestNOe = pressOe_q;
	assign link.emergencyOffN = emN_q;
	assign link.powerOffCommand = offCmd_q;
	assign link.sleepConfigCommand = cfgCmd_q;
	assign link.sleepConfigValue = cfgVal_q;
	assign link.dtrN = dtr_q;
endmodule
`default_nettype wire

// ---- verification/pss_link_asserts.sv ----
// Checker for the power and sleep link, watching the shared pin signals.
// Assumes bench press and emergency counts of 8 cycles and a ramp of 5.
`timescale 1ns/100ps
`default_nettype none
module pss_link_asserts (
	input wire logic clk,
	input wire logic srst,
	input wire logic powerOnRequestN,
	input wire logic emergencyOffN,
	input wire logic powerOffCommand,
	input wire logic ioSupplyGood
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// Full press seen while the module is off
	sequence pressS;
		!ioSupplyGood ##0 (!powerOnRequestN)[*8];
	endsequence
	// Emergency low held with the request pin idle
	sequence emergS;
		(!emergencyOffN && powerOnRequestN)[*8];
	endsequence
	a_reset_idle: assert property ($fell(srst) |-> !ioSupplyGood && powerOnRequestN && emergencyOffN)
		else $error("link not idle after reset");
	a_supply_rise: assert property (pressS |-> ##[1:20] ioSupplyGood)
		else $error("supply good late after press");
	a_supply_early: assert property ($fell(powerOnRequestN) && !ioSupplyGood |-> ##[1:8] ioSupplyGood)
		else $error("supply not up inside the press");
	a_press_len: assert property ($fell(powerOnRequestN) |-> (!powerOnRequestN)[*8])
		else $error("press too short");
	a_press_release: assert property ($fell(powerOnRequestN) |-> ##[8:12] powerOnRequestN)
		else $error("request pin not released");
	a_off_pin_high: assert property (powerOffCommand |-> powerOnRequestN)
		else $error("power-off sent with pin low");
	a_off_ignored: assert property (powerOffCommand && !powerOnRequestN && ioSupplyGood |=> ioSupplyGood)
		else $error("power-off obeyed with pin low");
	a_emerg_pulse: assert property ($fell(emergencyOffN) |-> emergS)
		else $error("bad emergency pulse");
	a_emerg_drop: assert property (ioSupplyGood ##0 emergS |-> ##[1:4] !ioSupplyGood)
		else $error("no shutdown on emergency");
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Bench joining host and module ends over the link, random sleep inputs.
// Assumes small counts for press, ramp and emergency; idle timeout at its default.
`timescale 1ns/100ps
`default_nettype none
module tb
	import pss_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic startReq = 1'b0, stopReq = 1'b0, emergencyReq = 1'b0, cfgReq = 1'b0;
	logic [1:0] cfgValue = 2'h0;
	logic [1:0] cur = 2'h2;
	logic [1:0] cfgs [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
	logic dtrNIn = 1'b1, tasksBusy = 1'b0;
	logic busy, moduleUp, poweredOn, asleep, wiped;
	logic [1:0] sleepConfig;
	int nFail = 0, nChecks = 0;
	pss_link_if link ();
	pss_device #(.PWR_ON_MIN(8), .IO_UP_DELAY(5), .EMERG_MIN(8)) pss_device_i (
		.clk(clk), .srst(srst), .link(link.device), .tasksBusy(tasksBusy),
		.poweredOn(poweredOn), .asleep(asleep), .wiped(wiped), .sleepConfig(sleepConfig));
	pss_host #(.PWR_ON_MIN(8), .EMERG_LEN(8)) pss_host_i (.clk(clk), .srst(srst),
		.link(link.host), .startReq(startReq), .stopReq(stopReq), .emergencyReq(emergencyReq),
		.cfgReq(cfgReq), .cfgValue(cfgValue), .dtrNIn(dtrNIn), .busy(busy), .moduleUp(moduleUp));
	pss_link_asserts pss_link_asserts_i (.clk(clk), .srst(srst),
		.powerOnRequestN(link.powerOnRequestN), .emergencyOffN(link.emergencyOffN),
		.powerOffCommand(link.powerOffCommand), .ioSupplyGood(link.ioSupplyGood));
	// 125 MHz clock
	always #4 clk = ~clk;
	task automatic wrapUp();
		$display("checks %0d failures %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		nChecks++;
		if (ok !== 1'b1) begin
			nFail++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One-cycle request: 0 start, 1 stop, 2 emergency, 3 config
	task automatic req(input int k, input logic [1:0] v);
		@(negedge clk);
		cfgValue = v;
		{startReq, stopReq, emergencyReq, cfgReq} = 4'h8 >> k;
		@(negedge clk);
		{startReq, stopReq, emergencyReq, cfgReq} = 4'h0;
	endtask
	// Bounded wait on the host's view of the supply
	task automatic waitUp(input logic e, input int n);
		for (int i = 0; i < n && moduleUp !== e; i++) @(negedge clk);
		if (moduleUp !== e) begin
			nFail++;
			$display("CHECK FAILED at %0t: module state wait timed out", $time);
			wrapUp();
		end else begin
			idle(4); // State outputs trail the supply by a few cycles
		end
	endtask
	// Settled sleep state for a policy and its inputs
	function automatic logic expSleep(input logic [1:0] c, input logic d, input logic t);
		return (c == SLEEP_CFG_DTR) ? d : (c == SLEEP_CFG_AUTO) ? !t : 1'b0;
	endfunction
	initial begin
		void'($urandom(95678));
		idle(8);
		srst = 1'b0;
		req(0, 2'h0);
		waitUp(1'b1, 60);
		chk(poweredOn === 1'b1 && sleepConfig === SLEEP_CFG_RESET, "power on");
		// Every code, 3 must be refused
		for (int j = 0; j < 4; j++) begin
			req(3, cfgs[j]);
			if (cfgs[j] != 2'h3) cur = cfgs[j];
			repeat (6) begin
				dtrNIn = 1'($urandom);
				tasksBusy = 1'($urandom);
				idle(cur == SLEEP_CFG_DTR ? IDLE_TIMEOUT_CYC + 16 : 16);
				chk(asleep === expSleep(cur, dtrNIn, tasksBusy) && sleepConfig === cur, "policy");
			end
		end
		// DTR back low before the timeout cancels sleep
		req(3, SLEEP_CFG_DTR);
		dtrNIn = 1'b0;
		idle(4);
		dtrNIn = 1'b1;
		repeat (6) begin
			idle(130);
			chk(asleep === 1'b0, "early sleep");
		end
		// Two high spells that only exceed the timeout if the low one fails to cancel
		dtrNIn = 1'b0;
		idle(4);
		dtrNIn = 1'b1;
		idle(IDLE_TIMEOUT_CYC - 200);
		chk(asleep === 1'b0, "sleep not cancelled");
		idle(300);
		chk(asleep === 1'b1, "no sleep after timeout");
		dtrNIn = 1'b0;
		idle(4);
		chk(asleep === 1'b0, "no wake on DTR");
		req(2, 2'h0);
		waitUp(1'b0, 40);
		chk(poweredOn === 1'b0 && wiped === 1'b1 && sleepConfig === SLEEP_CFG_RESET, "emergency");
		req(0, 2'h0);
		waitUp(1'b1, 60);
		chk(wiped === 1'b0, "wipe flag kept");
		req(1, 2'h0);
		waitUp(1'b0, 200);
		chk(poweredOn === 1'b0 && asleep === 1'b0, "orderly off");
		wrapUp();
	end
endmodule
`default_nettype wire
